// ==== arm_core.sv ====
// conversion memory control, result flags and interrupt vector
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "arm_defines.svh"
module arm_core
   import arm_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_nrst,
   // register port
   input  wire logic [15:0] i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [15:0] o_rdata,
   // sequencer side
   input  wire logic        i_result_wr,
   input  wire logic [3:0]  i_result_slot,
   input  wire logic [11:0] i_result_data,
   input  wire logic        i_sample_req,
   input  wire logic        i_conv_busy,
   input  wire logic [3:0]  i_cur_slot,
   output logic      [3:0]  o_channel,
   output logic      [2:0]  o_ref_pair,
   output logic             o_last,
   output logic             o_refgen_on,
   output logic      [3:0]  o_next_slot,
   output logic             o_conversion_enable,
   output logic      [1:0]  o_sequence_mode,
   output logic             o_stop_on_disable,
   // cpu interrupt side
   input  wire logic        i_gie,
   output logic             o_irq
);

   ////////////////////////////////////////////////////////////////////////
   // address decode helpers

   function automatic logic in_slot_block(input logic [15:0] a,
                                          input logic [15:0] base,
                                          input int          lsb);
      logic [15:0] mask;
      mask = 16'hFFFF << (lsb + 4);
      return ((a & mask) == (base & mask)) && (lsb == 0 || a[0] == 1'b0);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // state and derived signals

   arm_state_s  st;
   arm_state_s  next_st;
   logic [15:0] vector;
   logic [3:0]  top_slot;
   logic        top_is_flag;
   logic        hit_vec;
   logic        hit_ctl;
   logic        hit_res;
   logic [3:0]  ctl_idx;
   logic [3:0]  res_idx;
   logic        any_eos;

   arm_vec_enc u_vec (
      .i_ov          (st.ov),
      .i_tov         (st.tov),
      .i_flags       (st.flags),
      .o_vector      (vector),
      .o_top_slot    (top_slot),
      .o_top_is_flag (top_is_flag)
   );

   arm_slot_decode u_dec (
      .i_ctl       (st.slot_ctl[i_cur_slot]),
      .i_slot      (i_cur_slot),
      .o_channel   (o_channel),
      .o_ref_pair  (o_ref_pair),
      .o_last      (o_last),
      .o_refgen_on (o_refgen_on),
      .o_next_slot (o_next_slot)
   );

   // bus address decode
   always_comb begin
      hit_vec = (i_addr == `ARM_OFS_VECTOR) && (i_wr || i_rd);
      hit_ctl = in_slot_block(i_addr, `ARM_OFS_SLOT_CTL, 0);
      hit_res = in_slot_block(i_addr, `ARM_OFS_RESULT, 1);
      ctl_idx = i_addr[3:0];
      res_idx = i_addr[4:1];
      any_eos = 1'b0;
      for (int i = 0; i < 16; i++) begin
         any_eos = any_eos | st.slot_ctl[i][`ARM_SLOT_EOS];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // next state: bus clears first, hardware sets last so they win

   always_comb begin
      next_st       = st;
      next_st.rdata = `ARM_RST_WORD;
      // vector access: read drops only overwrite or timing when on top
      if (hit_vec) begin
         if (st.ov) begin
            next_st.ov = 1'b0;
         end else if (st.tov) begin
            next_st.tov = 1'b0;
         end else if (i_wr && top_is_flag) begin
            next_st.flags[top_slot] = 1'b0;
         end
      end
      // register writes
      if (i_wr) begin
         if (i_addr == `ARM_OFS_CONTROL) begin
            next_st.conv_en  = i_wdata[`ARM_CTL_ENABLE];
            next_st.seq_mode = i_wdata[`ARM_CTL_MODE_LO +: 2];
            next_st.tov_ie   = i_wdata[`ARM_CTL_TOV_IE];
            next_st.ov_ie    = i_wdata[`ARM_CTL_OV_IE];
         end
         if (i_addr == `ARM_OFS_FLAGS) begin
            next_st.flags = i_wdata; // software set or clear
         end
         if (i_addr == `ARM_OFS_ENABLES) begin
            next_st.enables = i_wdata;
         end
         if (hit_ctl && !st.conv_en) begin
            next_st.slot_ctl[ctl_idx] = i_wdata[7:0]; // locked while enabled
         end
      end
      // any access to a result slot drops its loaded flag
      if ((i_wr || i_rd) && hit_res) begin
         next_st.flags[res_idx] = 1'b0;
      end
      // register reads, data stand one cycle later
      if (i_rd) begin
         if (i_addr == `ARM_OFS_CONTROL) begin
            next_st.rdata = {11'h000, st.ov_ie, st.tov_ie, st.seq_mode, st.conv_en};
         end else if (i_addr == `ARM_OFS_FLAGS) begin
            next_st.rdata = st.flags;
         end else if (i_addr == `ARM_OFS_ENABLES) begin
            next_st.rdata = st.enables;
         end else if (i_addr == `ARM_OFS_VECTOR) begin
            next_st.rdata = vector; // value before this clear
         end else if (hit_ctl) begin
            next_st.rdata = {8'h00, st.slot_ctl[ctl_idx]};
         end else if (hit_res) begin
            next_st.rdata = {4'h0, st.result[res_idx]};
         end else begin
            next_st.rdata = `ARM_RST_WORD;
         end
      end
      // converter events
      if (i_result_wr) begin
         if (st.flags[i_result_slot]) begin
            next_st.ov = 1'b1;
         end
         next_st.result[i_result_slot] = i_result_data;
         next_st.flags[i_result_slot]  = 1'b1;
      end
      if (i_sample_req && i_conv_busy) begin
         next_st.tov = 1'b1;
      end
   end

   // state register, everything clears at power-on
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   always_comb begin
      o_rdata             = st.rdata;
      o_conversion_enable = st.conv_en;
      o_sequence_mode     = st.seq_mode;
      // sequence modes with no marker ignore a cleared enable
      o_stop_on_disable   = !st.conv_en && !(st.seq_mode[0] && !any_eos);
      o_irq = i_gie && ((st.ov && st.ov_ie) || (st.tov && st.tov_ie)
                        || (|(st.flags & st.enables)));
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_nrst);

   a_ctl_write_lock: assert property (
      (i_wr && hit_ctl && st.conv_en) |=> (st.slot_ctl == $past(st.slot_ctl)))
      else $error("slot control changed while enabled");

   a_ctl_write_take: assert property (
      (i_wr && hit_ctl && !st.conv_en)
      |=> (st.slot_ctl[$past(ctl_idx)] == $past(i_wdata[7:0])))
      else $error("slot control write lost while disabled");

   a_refgen_diode: assert property (
      (o_channel == `ARM_CH_DIODE) |-> o_refgen_on)
      else $error("diode channel without reference generator");

   a_flag_on_load: assert property (
      i_result_wr |=> st.flags[$past(i_result_slot)])
      else $error("result load did not set its flag");

   a_flag_slot_read: assert property (
      (i_rd && hit_res && !i_result_wr) |=> !st.flags[$past(res_idx)])
      else $error("slot access did not clear flag");

   a_vec_keeps_flags: assert property (
      (i_rd && hit_vec && !i_wr) |=> (($past(st.flags) & ~st.flags) == 16'h0000))
      else $error("vector read cleared a loaded flag");

   a_overwrite_set: assert property (
      (i_result_wr && st.flags[i_result_slot]) |=> st.ov)
      else $error("overwrite not raised");

   a_timing_set: assert property (
      (i_sample_req && i_conv_busy) |=> st.tov)
      else $error("timing overflow not raised");

   a_vector_read: assert property (
      (i_rd && hit_vec) |=> (o_rdata == $past(vector)))
      else $error("vector read value wrong");

   a_ov_first_clear: assert property (
      (i_rd && hit_vec && st.ov && st.tov && !i_result_wr && !i_sample_req)
      |=> (!st.ov && st.tov))
      else $error("vector access cleared wrong flag");

   a_write_drops_top: assert property (
      (i_wr && hit_vec && top_is_flag && !i_result_wr) |=> !st.flags[$past(top_slot)])
      else $error("vector write kept top flag");

   a_irq_gated: assert property (
      (!i_gie || (vector == `ARM_VEC_NONE)) |-> !o_irq)
      else $error("request without pending source");

   a_irq_enabled: assert property (
      (i_gie && (|(st.flags & st.enables))) |-> o_irq)
      else $error("enabled flag gave no request");

   // control byte of the slot the sequencer works on, for the decode checks
   logic [7:0] cur_ctl;
   assign cur_ctl = st.slot_ctl[i_cur_slot];

   a_channel_field: assert property (
      o_channel == cur_ctl[3:0])
      else $error("channel field not passed through");

   a_ref_fold_low: assert property (
      (cur_ctl[6:4] == 3'h3) |-> (o_ref_pair == 3'h2))
      else $error("reference code 3 not folded");

   a_ref_fold_high: assert property (
      (cur_ctl[6:4] == 3'h7) |-> (o_ref_pair == 3'h6))
      else $error("reference code 7 not folded");

   a_ref_pass: assert property (
      ((cur_ctl[6:4] != 3'h3) && (cur_ctl[6:4] != 3'h7))
      |-> (o_ref_pair == cur_ctl[6:4]))
      else $error("reference pair changed");

   a_last_marker: assert property (
      o_last == cur_ctl[`ARM_SLOT_EOS])
      else $error("end marker not passed through");

   a_refgen_only: assert property (
      o_refgen_on |-> (o_channel == `ARM_CH_DIODE))
      else $error("reference generator on without diode channel");

   a_slot_wrap: assert property (
      (i_cur_slot == 4'hF) |-> (o_next_slot == 4'h0))
      else $error("last slot did not wrap to the first");

   a_seq_keeps_running: assert property (
      (!st.conv_en && st.seq_mode[0] && !any_eos)
      |-> !o_stop_on_disable)
      else $error("unmarked sequence stopped on disable");

   a_single_stops: assert property (
      (!st.conv_en && !st.seq_mode[0]) |-> o_stop_on_disable)
      else $error("single channel mode kept running");

   a_result_store: assert property (
      i_result_wr
      |=> (st.result[$past(i_result_slot)] == $past(i_result_data)))
      else $error("result not stored");

   a_sw_flag_write: assert property (
      (i_wr && (i_addr == `ARM_OFS_FLAGS) && !i_result_wr)
      |=> (st.flags == $past(i_wdata)))
      else $error("software flag write lost");

   a_enable_write: assert property (
      (i_wr && (i_addr == `ARM_OFS_ENABLES))
      |=> (st.enables == $past(i_wdata)))
      else $error("enable write lost");

   a_tov_second_clear: assert property (
      (hit_vec && !st.ov && st.tov && !i_sample_req)
      |=> !st.tov)
      else $error("timing flag kept after vector access");

   a_vec_write_ov: assert property (
      (i_wr && hit_vec && st.ov && !i_result_wr)
      |=> (!st.ov && (st.flags == $past(st.flags))))
      else $error("vector write cleared wrong flag");

   a_vec_none: assert property (
      (vector == `ARM_VEC_NONE)
      |-> (!st.ov && !st.tov && (st.flags == 16'h0000)))
      else $error("empty vector with a pending flag");

   a_vec_ov_top: assert property (
      st.ov |-> (vector == `ARM_VEC_OV))
      else $error("overwrite not on top of vector");

   a_vec_tov_next: assert property (
      (!st.ov && st.tov) |-> (vector == `ARM_VEC_TOV))
      else $error("timing flag not second in vector");

   a_vec_slot_first: assert property (
      (!st.ov && !st.tov && st.flags[0]) |-> (vector == `ARM_VEC_SLOT0))
      else $error("slot 0 vector wrong");

   a_vec_slot_last: assert property (
      (!st.ov && !st.tov && (st.flags == 16'h8000))
      |-> (vector == 16'h0024))
      else $error("slot 15 vector wrong");

   a_irq_ov: assert property (
      (i_gie && st.ov && st.ov_ie) |-> o_irq)
      else $error("enabled overwrite gave no request");

   a_irq_tov: assert property (
      (i_gie && st.tov && st.tov_ie) |-> o_irq)
      else $error("enabled timing overflow gave no request");

   c_load_then_vec: cover property (i_result_wr ##1 (i_rd && hit_vec));
   c_overwrite: cover property (i_result_wr && st.flags[i_result_slot]);
   c_timing_clear: cover property (st.tov ##1 (i_rd && hit_vec) ##1 !st.tov);
   c_irq: cover property ($rose(o_irq));
   c_vec_write: cover property (i_wr && hit_vec && top_is_flag);

endmodule

// ==== arm_defines.svh ====
// register map, field positions and reset values of the result memory block
//
// Summary of operation
// - writes to slot control registers are ignored while conversion enable is set
// - all slot control fields clear to zero at power-on reset
// - low four bits pick the input: 0-7 external, 8, 9, 10 diode, 11-15 mid-supply
// - channel 10 turns the reference generator on, no pin output, pair unchanged
// - bits 4-6 pick one of six reference pairs; 2=3 and 6=7
// - bit 7 marks the slot as the last conversion of a sequence
// - without the marker in slot 15 a sequence wraps from slot 15 to slot 0
// - sequence mode with no marker anywhere keeps running after enable clears
// - sixteen result-loaded flags, each set when its slot gets a new result
// - flag clears on bus access to its slot, by software, or by a vector write when it is highest, not by vector read
// - new result into a slot whose flag is still set raises result overwrite
// - sixteen enable bits gate the matching result-loaded flags onto the request
// - vector gives 0 none, 2 overwrite, 4 timing, then 6 plus twice slot, to 36
// - request rises at once for an enabled pending source while global enable set
// - vector access clears overwrite or timing flag only when it is highest
// - overwrite and timing flags are seen only through the vector word
// - a write to the vector word clears the highest pending flag
// - power-on reset clears all result-loaded flags and enables
// - sample request while a conversion is still running raises timing overflow
`ifndef ARM_DEFINES_SVH
`define ARM_DEFINES_SVH

// byte addresses
`define ARM_OFS_FLAGS    16'h0184
`define ARM_OFS_ENABLES  16'h01A6
`define ARM_OFS_VECTOR   16'h01A8
`define ARM_OFS_CONTROL  16'h01A0
`define ARM_OFS_SLOT_CTL 16'h0080
`define ARM_OFS_RESULT   16'h0140

// control register fields
`define ARM_CTL_ENABLE   0
`define ARM_CTL_MODE_LO  1
`define ARM_CTL_TOV_IE   3
`define ARM_CTL_OV_IE    4

// slot control fields
`define ARM_SLOT_EOS     7
`define ARM_CH_DIODE     4'h0A

// vector encodings
`define ARM_VEC_NONE     16'h0000
`define ARM_VEC_OV       16'h0002
`define ARM_VEC_TOV      16'h0004
`define ARM_VEC_SLOT0    16'h0006

// reset values
`define ARM_RST_BYTE     8'h00
`define ARM_RST_WORD     16'h0000

`endif

// ==== arm_pkg.sv ====
// types shared by the result memory block
package arm_pkg;

   typedef logic [15:0][7:0]  arm_ctl_t;
   typedef logic [15:0][11:0] arm_res_t;

   typedef struct packed {
      arm_ctl_t    slot_ctl;
      arm_res_t    result;
      logic [15:0] flags;
      logic [15:0] enables;
      logic        ov;
      logic        tov;
      logic        conv_en;
      logic [1:0]  seq_mode;
      logic        ov_ie;
      logic        tov_ie;
      logic [15:0] rdata;
   } arm_state_s;

endpackage

// ==== arm_vec_enc.sv ====
// priority encoder producing the interrupt vector word
`timescale 1ns/1ps
`include "arm_defines.svh"
module arm_vec_enc
   import arm_pkg::*;
(
   input  wire logic        i_ov,
   input  wire logic        i_tov,
   input  wire logic [15:0] i_flags,
   output logic      [15:0] o_vector,
   output logic      [3:0]  o_top_slot,
   output logic             o_top_is_flag
);

   // overwrite first, timing second, then slot 0 upward
   always_comb begin
      o_vector      = `ARM_VEC_NONE;
      o_top_slot    = 4'h0;
      o_top_is_flag = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         if (i_flags[i]) begin
            o_vector      = `ARM_VEC_SLOT0 + 16'(2 * i);
            o_top_slot    = 4'(i);
            o_top_is_flag = 1'b1;
         end
      end
      if (i_tov) begin
         o_vector      = `ARM_VEC_TOV;
         o_top_is_flag = 1'b0;
      end
      if (i_ov) begin
         o_vector      = `ARM_VEC_OV;
         o_top_is_flag = 1'b0;
      end
   end

endmodule

// ==== arm_slot_decode.sv ====
// decode of the slot control byte for the sequencer
`timescale 1ns/1ps
`include "arm_defines.svh"
module arm_slot_decode
   import arm_pkg::*;
(
   input  wire logic [7:0] i_ctl,
   input  wire logic [3:0] i_slot,
   output logic      [3:0] o_channel,
   output logic      [2:0] o_ref_pair,
   output logic            o_last,
   output logic            o_refgen_on,
   output logic      [3:0] o_next_slot
);

   always_comb begin
      o_channel   = i_ctl[3:0];
      // fold the duplicate codes 3 and 7 onto 2 and 6
      o_ref_pair  = {i_ctl[6], i_ctl[5], i_ctl[4] & ~i_ctl[5]};
      o_last      = i_ctl[`ARM_SLOT_EOS];
      o_refgen_on = (i_ctl[3:0] == `ARM_CH_DIODE);
      o_next_slot = i_slot + 4'h1; // slot 15 rolls to 0
   end

endmodule

// ==== arm_seq_model.sv ====
// converter sequencer model: result stores, sample requests, slot pointer
`timescale 1ns/1ps
module arm_seq_model (
   input  wire logic        i_clock,
   output logic             o_result_wr,
   output logic      [3:0]  o_result_slot,
   output logic      [11:0] o_result_data,
   output logic             o_sample_req,
   output logic             o_conv_busy,
   output logic      [3:0]  o_cur_slot
);
   // idle state at time zero
   initial begin
      o_result_wr = 1'b0;
      o_result_slot = 4'h0;
      o_result_data = 12'h5A5;
      o_sample_req = 1'b0;
      o_conv_busy = 1'b0;
      o_cur_slot = 4'h0;
   end
   // one result store; data turns over once released
   task store(input logic [3:0] s, input logic [11:0] d);
      @(posedge i_clock);
      o_result_wr <= 1'b1;
      o_result_slot <= s;
      o_result_data <= d;
      @(posedge i_clock);
      o_result_wr <= 1'b0;
      o_result_data <= ~d;
   endtask
   // sample request, with or without a conversion running
   task sample(input logic busy);
      @(posedge i_clock);
      o_conv_busy <= busy;
      o_sample_req <= 1'b1;
      @(posedge i_clock);
      o_sample_req <= 1'b0;
      o_conv_busy <= 1'b0;
   endtask
   // move the slot the sequencer works on
   task point(input logic [3:0] s);
      @(posedge i_clock);
      o_cur_slot <= s;
      @(posedge i_clock);
   endtask
endmodule

// ==== arm_core_tb.sv ====
// self-checking testbench of the result memory and interrupt block
`timescale 1ns/1ps
`include "arm_defines.svh"
module arm_core_tb;
   logic i_clock = 1'b0;
   logic i_nrst = 1'b0;
   logic [15:0] i_addr = 16'h0000;
   logic [15:0] i_wdata = 16'h0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_gie = 1'b0;
   logic [15:0] o_rdata;
   logic rwr, sreq, busy, o_last, o_refgen_on, o_conv_en, o_stop, o_irq;
   logic [3:0] rslot, cslot, o_channel, o_next_slot;
   logic [11:0] rdat;
   logic [2:0] o_ref_pair;
   logic [1:0] o_mode;
   int err_total = 0;
   int tests_run = 0;
   ////////////////////////////////////////////////////////////////
   // clock at 20 MHz
   always #25 i_clock = ~i_clock;
   arm_seq_model m (.i_clock(i_clock), .o_result_wr(rwr), .o_result_slot(rslot),
      .o_result_data(rdat), .o_sample_req(sreq), .o_conv_busy(busy), .o_cur_slot(cslot));
   arm_core uut (.i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_result_wr(rwr),
      .i_result_slot(rslot), .i_result_data(rdat), .i_sample_req(sreq), .i_conv_busy(busy),
      .i_cur_slot(cslot), .o_channel(o_channel), .o_ref_pair(o_ref_pair), .o_last(o_last),
      .o_refgen_on(o_refgen_on), .o_next_slot(o_next_slot), .o_conversion_enable(o_conv_en),
      .o_sequence_mode(o_mode), .o_stop_on_disable(o_stop), .i_gie(i_gie), .o_irq(o_irq));
   ////////////////////////////////////////////////////////////////
   // compare and bus tasks
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge i_clock);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask
   task rd(input logic [15:0] a, input logic [15:0] e, input string n);
      @(posedge i_clock);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 chk(n, e, o_rdata);
   endtask
   task test_done;
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // scenario: reset values
   task t_reset;
      rd(`ARM_OFS_FLAGS, 16'h0000, "flags");
      rd(`ARM_OFS_ENABLES, 16'h0000, "enables");
      rd(`ARM_OFS_SLOT_CTL + 16'h000F, 16'h0000, "slot15");
      rd(`ARM_OFS_VECTOR, 16'h0000, "vector");
   endtask
   // scenario: slot control decode and write lock
   task t_slot;
      wr(`ARM_OFS_SLOT_CTL + 16'h0002, 16'h003A);
      m.point(4'h2);
      #1 chk("channel", 16'h000A, {12'h000, o_channel});
      chk("refpair", 16'h0002, {13'h0000, o_ref_pair});
      chk("refgen", 16'h0001, {15'h0000, o_refgen_on});
      chk("last", 16'h0000, {15'h0000, o_last});
      wr(`ARM_OFS_CONTROL, 16'h0006);
      #1 chk("stop", 16'h0000, {15'h0000, o_stop});
      chk("mode", 16'h0003, {14'h0000, o_mode});
      chk("enable0", 16'h0000, {15'h0000, o_conv_en});
      wr(`ARM_OFS_SLOT_CTL + 16'h000F, 16'h0070);
      m.point(4'hF);
      #1 chk("next", 16'h0000, {12'h000, o_next_slot});
      chk("refpair7", 16'h0006, {13'h0000, o_ref_pair});
      wr(`ARM_OFS_SLOT_CTL + 16'h000F, 16'h0080);
      #1 chk("stop2", 16'h0001, {15'h0000, o_stop});
      chk("last15", 16'h0001, {15'h0000, o_last});
      wr(`ARM_OFS_CONTROL, 16'h0001);
      #1 chk("enable1", 16'h0001, {15'h0000, o_conv_en});
      wr(`ARM_OFS_SLOT_CTL + 16'h0002, 16'h0055);
      rd(`ARM_OFS_SLOT_CTL + 16'h0002, 16'h003A, "locked");
      wr(`ARM_OFS_CONTROL, 16'h0000);
   endtask
   // scenario: loaded flags, overwrite, priority and request
   task t_flags;
      wr(`ARM_OFS_ENABLES, 16'h0008);
      i_gie <= 1'b1;
      m.store(4'h3, 12'h123);
      #1 chk("irq", 16'h0001, {15'h0000, o_irq});
      wr(`ARM_OFS_ENABLES, 16'h0000);
      #1 chk("irq_off", 16'h0000, {15'h0000, o_irq});
      m.store(4'h3, 12'h456);
      rd(`ARM_OFS_VECTOR, `ARM_VEC_OV, "vec_ov");
      rd(`ARM_OFS_VECTOR, 16'h000C, "vec3");
      rd(`ARM_OFS_RESULT + 16'h0006, 16'h0456, "result3");
      m.store(4'hF, 12'h0FF);
      rd(`ARM_OFS_VECTOR, 16'h0024, "vec15");
      m.store(4'h0, 12'h001);
      rd(`ARM_OFS_VECTOR, `ARM_VEC_SLOT0, "vec0");
      wr(`ARM_OFS_FLAGS, 16'h0000);
      rd(`ARM_OFS_FLAGS, 16'h0000, "swclr");
   endtask
   // scenario: timing overflow and vector writes
   task t_timing;
      wr(`ARM_OFS_CONTROL, 16'h0018);
      m.sample(1'b0);
      rd(`ARM_OFS_VECTOR, 16'h0000, "vec_idle");
      m.sample(1'b1);
      #1 chk("irq_tov", 16'h0001, {15'h0000, o_irq});
      m.store(4'h1, 12'h777);
      rd(`ARM_OFS_VECTOR, `ARM_VEC_TOV, "vec_tov");
      chk("irq_clr", 16'h0000, {15'h0000, o_irq});
      rd(`ARM_OFS_VECTOR, 16'h0008, "vec1");
      wr(`ARM_OFS_VECTOR, 16'hFFFF);
      rd(`ARM_OFS_FLAGS, 16'h0000, "lost");
      m.sample(1'b1);
      m.store(4'h2, 12'h222);
      wr(`ARM_OFS_VECTOR, 16'h0000);
      rd(`ARM_OFS_VECTOR, 16'h000A, "vec2");
   endtask
   // scenario: reset in mid-run clears slots, flags and enables
   task t_again;
      wr(`ARM_OFS_ENABLES, 16'h00F0);
      m.store(4'h4, 12'h444);
      #1 chk("irq_pre", 16'h0001, {15'h0000, o_irq});
      @(posedge i_clock);
      i_nrst <= 1'b0;
      repeat (2) @(posedge i_clock);
      i_nrst <= 1'b1;
      #1 chk("irq_rst", 16'h0000, {15'h0000, o_irq});
      t_reset();
      rd(`ARM_OFS_SLOT_CTL + 16'h0002, 16'h0000, "slot2");
   endtask
   ////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (20) @(posedge i_clock);
      i_nrst <= 1'b1;
      t_reset();
      t_slot();
      t_flags();
      t_timing();
      t_again();
      test_done();
   end
   // watchdog
   initial begin
      #(5000 * 50);
      err_total++;
      test_done();
   end
endmodule
